// *** src/adcseq_pkg.sv ***
// Function
// - Mode 01 plus start bit begins conversion
// - On completion store result, set flag, interrupt
// - Start bit self-clears once conversion begins
// - Repeat mode 11 restarts after each completion
// - Mode 00 halts at once, discards value
// - Reading result clears end-of-conversion flag
// - Restart clears flag, keeps old result
// - Standby aborts, resets controls, loses result
// - No automatic restart after standby ends
// - Ladder disconnected during standby
// - Result is 10-bit unsigned code
// - Channel codes 0-7 valid, others reserved
// - Conversion time code selects cycle count
// - Busy set at start, cleared at single-mode end, disable or standby
// - Upper result read clears flag
`default_nettype none

package adcseq_pkg;

  // ==========================================================
  // Widths
  localparam int RES_W  = 10;
  localparam int CHAN_W = 4;
  localparam int CNT_W  = 11;
  localparam int STEP_W = 4;

  // ==========================================================
  // Control field positions
  localparam int C1_START_BIT = 7;
  localparam int C1_MODE_LSB  = 5;
  localparam int C1_ANALOG_INPUT_DISABLE_BIT = 4;
  localparam int C1_CHAN_LSB  = 0;
  localparam int C2_LADDER_BIT = 5;
  localparam int C2_ACK_LSB    = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0]       CTRL1_RESET  = 8'h10;
  localparam logic [7:0]       CTRL2_RESET  = 8'h10;
  localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;

  // ==========================================================
  // Operating modes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // ==========================================================
  // Conversion times in oscillator cycles
  localparam logic [CNT_W-1:0] CONV_CYC_39   = 11'h027;
  localparam logic [CNT_W-1:0] CONV_CYC_78   = 11'h04E;
  localparam logic [CNT_W-1:0] CONV_CYC_156  = 11'h09C;
  localparam logic [CNT_W-1:0] CONV_CYC_312  = 11'h138;
  localparam logic [CNT_W-1:0] CONV_CYC_624  = 11'h270;
  localparam logic [CNT_W-1:0] CONV_CYC_1248 = 11'h4E0;

  // Cycles per approximation bit (comparator sync latency included)
  localparam logic [STEP_W-1:0] SAR_STEP_CYC = 4'h3;

  typedef enum logic [0:0] {
    ADCSEQ_IDLE = 1'b0,
    ADCSEQ_CONV = 1'b1
  } adcseq_state_e;

  // Conversion time decode, reserved codes take the longest time
  function automatic logic [CNT_W-1:0] adcseq_conv_cycles(input logic [2:0] code);
    logic [CNT_W-1:0] cyc;
    case (code)
      3'h0: cyc = CONV_CYC_39;
      3'h2: cyc = CONV_CYC_78;
      3'h3: cyc = CONV_CYC_156;
      3'h4: cyc = CONV_CYC_312;
      3'h5: cyc = CONV_CYC_624;
      3'h6: cyc = CONV_CYC_1248;
      default: cyc = CONV_CYC_1248;
    endcase
    return cyc;
  endfunction : adcseq_conv_cycles

endpackage : adcseq_pkg

`default_nettype wire

// *** src/adcseq_conv_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_conv_timer #(
  parameter int CNT_W = 11
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             go,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] limit,
  output var  logic             done
);
  import adcseq_pkg::*;

  typedef struct packed {
    logic             run;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
    logic             done;
  } adcseq_tmr_s;

  adcseq_tmr_s tmr_reg;
  adcseq_tmr_s tmr_next;

  // ==========================================================
  // Cycle counter
  always_comb begin
    tmr_next      = tmr_reg;
    tmr_next.done = 1'b0;
    if (abort) begin
      tmr_next.run = 1'b0;
    end else if (go) begin
      tmr_next.run = 1'b1;
      tmr_next.cnt = {{(CNT_W-1){1'b0}}, 1'b1};
      tmr_next.lim = limit;
    end else if (tmr_reg.run) begin
      if (tmr_reg.cnt == tmr_reg.lim) begin
        tmr_next.run  = 1'b0;
        tmr_next.done = 1'b1;
      end else begin
        tmr_next.cnt = tmr_reg.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign done = tmr_reg.done;

endmodule : adcseq_conv_timer

`default_nettype wire

// *** src/adcseq_sar.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_sar #(
  parameter int RES_W  = 10,
  parameter int STEP_W = 4
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             go,
  input  wire logic             abort,
  input  wire logic             comp_in,
  output var  logic [RES_W-1:0] dac_code,
  output var  logic [RES_W-1:0] code
);
  import adcseq_pkg::*;

  typedef struct packed {
    logic              sync1;
    logic              sync2;
    logic              run;
    logic [STEP_W-1:0] step;
    logic [RES_W-1:0]  mask;
    logic [RES_W-1:0]  trial;
    logic [RES_W-1:0]  code;
  } adcseq_sar_s;

  adcseq_sar_s sar_reg;
  adcseq_sar_s sar_next;

  // ==========================================================
  // Successive approximation, one bit per step
  always_comb begin
    logic [RES_W-1:0] t;
    t              = sar_reg.trial;
    sar_next       = sar_reg;
    sar_next.sync1 = comp_in;
    sar_next.sync2 = sar_reg.sync1;
    if (abort) begin
      sar_next.run = 1'b0;
    end else if (go) begin
      sar_next.run   = 1'b1;
      sar_next.step  = '0;
      sar_next.mask  = {1'b1, {(RES_W-1){1'b0}}};
      sar_next.trial = {1'b1, {(RES_W-1){1'b0}}};
    end else if (sar_reg.run) begin
      if (sar_reg.step == SAR_STEP_CYC - 4'h1) begin
        sar_next.step = '0;
        if (!sar_reg.sync2) begin
          t = t & ~sar_reg.mask;
        end
        sar_next.trial = t | (sar_reg.mask >> 1);
        sar_next.mask  = sar_reg.mask >> 1;
        if (sar_reg.mask[0]) begin
          sar_next.run   = 1'b0;
          sar_next.trial = t;
          sar_next.code  = t;
        end
      end else begin
        sar_next.step = sar_reg.step + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sar_reg <= '0;
    end else begin
      sar_reg <= sar_next;
    end
  end

  assign dac_code = sar_reg.trial;
  assign code     = sar_reg.code;

endmodule : adcseq_sar

`default_nettype wire

// *** src/adcseq_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_top (
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  input  wire logic                        ctrl1_wr,
  input  wire logic [7:0]                  ctrl1_wdata,
  input  wire logic                        ctrl2_wr,
  input  wire logic [7:0]                  ctrl2_wdata,
  input  wire logic                        result_upper_rd,
  input  wire logic                        standby_req,
  input  wire logic                        comp_in,
  output var  logic [7:0]                  conv_control_one,
  output var  logic [7:0]                  conv_control_two,
  output var  logic [7:0]                  result_upper_reg,
  output var  logic [7:0]                  result_lower_status_reg,
  output var  logic                        end_of_conv_flag,
  output var  logic                        conv_busy_flag,
  output var  logic                        conv_done_irq,
  output var  logic [2:0]                  analog_mux_sel,
  output var  logic                        analog_input_disable,
  output var  logic                        ladder_connect,
  output var  logic [adcseq_pkg::RES_W-1:0] dac_code
);
  import adcseq_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic              start;
    logic [1:0]        mode;
    logic              ain_dis;
    logic [CHAN_W-1:0] chan;
    logic              ladder_on;
    logic [2:0]        ack;
    adcseq_state_e     state;
    logic              eoc;
    logic [RES_W-1:0]  result;
    logic              irq;
    logic              ladder_conn;
    logic              go;
  } adcseq_top_s;

  adcseq_top_s top_reg;
  adcseq_top_s top_next;

  logic             tmr_done;
  logic [RES_W-1:0] sar_code;
  logic             mode_ok;
  logic             sw_go;
  logic             stop_now;
  logic             eoc_set;

  // ==========================================================
  // Start qualification and abort
  always_comb begin
    mode_ok  = (top_reg.mode == MODE_SINGLE) || (top_reg.mode == MODE_REPEAT);
    // Reserved channel codes never start a software conversion; a repeat restart does not check the channel
    sw_go    = top_reg.start && mode_ok && !top_reg.chan[CHAN_W-1]
               && (top_reg.state == ADCSEQ_IDLE);
    // Disable or reserved mode stops a running conversion at once
    stop_now = standby_req || ((top_reg.state == ADCSEQ_CONV) && !mode_ok);
    eoc_set  = (top_reg.state == ADCSEQ_CONV) && !stop_now && tmr_done;
  end

  // ==========================================================
  // Next state
  always_comb begin
    top_next     = top_reg;
    top_next.go  = 1'b0;
    top_next.irq = 1'b0;

    if (standby_req) begin
      // Controls back to reset, conversion dropped, writes refused
      top_next.start     = CTRL1_RESET[C1_START_BIT];
      top_next.mode      = CTRL1_RESET[C1_MODE_LSB +: 2];
      top_next.ain_dis   = CTRL1_RESET[C1_ANALOG_INPUT_DISABLE_BIT];
      top_next.chan      = CTRL1_RESET[C1_CHAN_LSB +: CHAN_W];
      top_next.ladder_on = CTRL2_RESET[C2_LADDER_BIT];
      top_next.ack       = CTRL2_RESET[C2_ACK_LSB +: 3];
      top_next.state     = ADCSEQ_IDLE;
      top_next.eoc       = 1'b0;
      top_next.result    = RESULT_RESET;
    end else begin
      // ------------------------------------------------------
      // Control register one
      if (ctrl1_wr) begin
        top_next.mode    = ctrl1_wdata[C1_MODE_LSB +: 2];
        top_next.ain_dis = ctrl1_wdata[C1_ANALOG_INPUT_DISABLE_BIT];
        top_next.chan    = ctrl1_wdata[C1_CHAN_LSB +: CHAN_W];
        // A start written while busy is ignored
        if (ctrl1_wdata[C1_START_BIT] && (top_reg.state == ADCSEQ_IDLE)) begin
          top_next.start = 1'b1;
        end
      end

      // ------------------------------------------------------
      // Control register two
      if (ctrl2_wr) begin
        top_next.ladder_on = ctrl2_wdata[C2_LADDER_BIT];
        top_next.ack       = ctrl2_wdata[C2_ACK_LSB +: 3];
      end

      // ------------------------------------------------------
      // Flag clear by upper result read, a same-cycle set wins
      if (result_upper_rd) begin
        top_next.eoc = 1'b0;
      end

      // ------------------------------------------------------
      // Software start
      if (top_reg.start) begin
        top_next.start = 1'b0;
      end
      if (sw_go) begin
        top_next.go    = 1'b1;
        top_next.state = ADCSEQ_CONV;
        // Old result is kept until the new one lands
        top_next.eoc   = 1'b0;
      end

      // ------------------------------------------------------
      // Running conversion
      unique case (top_reg.state)
        ADCSEQ_IDLE: begin
        end
        ADCSEQ_CONV: begin
          if (stop_now) begin
            top_next.state = ADCSEQ_IDLE;
          end else if (eoc_set) begin
            top_next.result = sar_code;
            top_next.eoc    = 1'b1;
            top_next.irq    = 1'b1;
            if (top_reg.mode == MODE_REPEAT) begin
              top_next.go = 1'b1;
            end else begin
              top_next.state = ADCSEQ_IDLE;
            end
          end
        end
      endcase
    end

    // Ladder connected while converting or when forced on, never in standby
    top_next.ladder_conn = !standby_req
                           && (top_next.ladder_on || (top_next.state == ADCSEQ_CONV));
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      top_reg             <= '0;
      top_reg.mode        <= CTRL1_RESET[C1_MODE_LSB +: 2];
      top_reg.ain_dis     <= CTRL1_RESET[C1_ANALOG_INPUT_DISABLE_BIT];
      top_reg.chan        <= CTRL1_RESET[C1_CHAN_LSB +: CHAN_W];
      top_reg.ladder_on   <= CTRL2_RESET[C2_LADDER_BIT];
      top_reg.ack         <= CTRL2_RESET[C2_ACK_LSB +: 3];
      top_reg.state       <= ADCSEQ_IDLE;
      top_reg.result      <= RESULT_RESET;
    end else begin
      top_reg <= top_next;
    end
  end

  // ==========================================================
  // Conversion time counter
  adcseq_conv_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .go    (top_reg.go),
    .abort (stop_now),
    .limit (adcseq_conv_cycles(top_reg.ack)),
    .done  (tmr_done)
  );

  // ==========================================================
  // Approximation engine
  adcseq_sar #(
    .RES_W  (RES_W),
    .STEP_W (STEP_W)
  ) u_sar (
    .mclk     (mclk),
    .nrst     (nrst),
    .go       (top_reg.go),
    .abort    (stop_now),
    .comp_in  (comp_in),
    .dac_code (dac_code),
    .code     (sar_code)
  );

  // ==========================================================
  // Register views
  assign conv_control_one        = {top_reg.start, top_reg.mode, top_reg.ain_dis, top_reg.chan};
  assign conv_control_two        = {2'h0, top_reg.ladder_on, 1'b1, top_reg.ack, 1'b0};
  assign result_upper_reg        = top_reg.result[RES_W-1:2];
  assign result_lower_status_reg = {top_reg.result[1:0], top_reg.eoc,
                                    (top_reg.state == ADCSEQ_CONV), 4'h0};
  assign end_of_conv_flag        = top_reg.eoc;
  assign conv_busy_flag          = (top_reg.state == ADCSEQ_CONV);
  assign conv_done_irq           = top_reg.irq;
  assign analog_mux_sel          = top_reg.chan[2:0];
  assign analog_input_disable    = top_reg.ain_dis;
  assign ladder_connect          = top_reg.ladder_conn;

endmodule : adcseq_top

`default_nettype wire

// *** tb/adcseq_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
module adcseq_props (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       ctrl1_wr,
  input wire logic [7:0] ctrl1_wdata,
  input wire logic       result_upper_rd,
  input wire logic       standby_req,
  input wire logic [7:0] conv_control_one,
  input wire logic [7:0] conv_control_two,
  input wire logic [7:0] result_upper_reg,
  input wire logic [7:0] result_lower_status_reg,
  input wire logic       end_of_conv_flag,
  input wire logic       conv_busy_flag,
  input wire logic       conv_done_irq,
  input wire logic [2:0] analog_mux_sel,
  input wire logic       ladder_connect
);
  import adcseq_pkg::*;
  logic [11:0]      cnt_reg;
  logic [CNT_W-1:0] lim;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Cycles spent converting
  always_comb begin
    case (conv_control_two[3:1])
      3'h0: lim = CONV_CYC_39;
      3'h2: lim = CONV_CYC_78;
      3'h3: lim = CONV_CYC_156;
      3'h4: lim = CONV_CYC_312;
      3'h5: lim = CONV_CYC_624;
      default: lim = CONV_CYC_1248;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cnt_reg <= 12'h000;
    else if (!conv_busy_flag || conv_done_irq) cnt_reg <= 12'h000;
    else cnt_reg <= cnt_reg + 12'h001;
  end

  // ==========================================================
  // Properties
  AST_IRQ_ONE: assert property (conv_done_irq |=> !conv_done_irq) else $error("irq longer than one cycle");
  AST_IRQ_EOC: assert property (conv_done_irq |-> end_of_conv_flag && result_lower_status_reg[5])
    else $error("irq without end flag");
  AST_START_CLR: assert property (conv_control_one[7] |=> !conv_control_one[7]) else $error("start stuck");
  AST_STBY: assert property (standby_req |=> conv_control_one == CTRL1_RESET && conv_control_two == CTRL2_RESET
    && !conv_busy_flag && !end_of_conv_flag && !ladder_connect) else $error("standby did not reset");
  AST_ABORT: assert property (ctrl1_wr && !standby_req && !ctrl1_wdata[5] && conv_busy_flag
    |-> ##[1:3] !conv_busy_flag) else $error("disable did not halt");
  AST_READ: assert property (result_upper_rd && !standby_req |=> !end_of_conv_flag || conv_done_irq)
    else $error("read left flag set");
  AST_SINGLE: assert property (conv_done_irq && conv_control_one[6:5] == MODE_SINGLE |-> !conv_busy_flag)
    else $error("busy after single conversion");
  AST_REPEAT: assert property (conv_done_irq && conv_control_one[6:5] == MODE_REPEAT |-> conv_busy_flag)
    else $error("repeat did not restart");
  AST_BUSY_RISE: assert property ($rose(conv_busy_flag) |-> !end_of_conv_flag && $past(conv_control_one[7]))
    else $error("busy without start");
  AST_RESULT: assert property ($changed(result_upper_reg) |-> conv_done_irq || $past(standby_req))
    else $error("result changed without completion");
  AST_TIME: assert property (conv_done_irq |-> cnt_reg + 12'h003 >= 12'(lim) && cnt_reg <= 12'(lim) + 12'h003)
    else $error("conversion time wrong");
  AST_MUX: assert property ($rose(conv_busy_flag) |-> !conv_control_one[3] && result_lower_status_reg[4])
    else $error("conversion started on reserved channel");
endmodule : adcseq_props

bind adcseq_top adcseq_props u_props (.mclk(mclk), .nrst(nrst), .ctrl1_wr(ctrl1_wr), .ctrl1_wdata(ctrl1_wdata),
  .result_upper_rd(result_upper_rd), .standby_req(standby_req), .conv_control_one(conv_control_one),
  .conv_control_two(conv_control_two), .result_upper_reg(result_upper_reg),
  .result_lower_status_reg(result_lower_status_reg), .end_of_conv_flag(end_of_conv_flag),
  .conv_busy_flag(conv_busy_flag), .conv_done_irq(conv_done_irq), .analog_mux_sel(analog_mux_sel),
  .ladder_connect(ladder_connect));

`default_nettype wire

// *** tb/adcseq_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Analog inputs and comparator
module adcseq_partner (
  input wire logic [2:0]                        analog_mux_sel,
  input wire logic [adcseq_pkg::RES_W-1:0]      dac_code,
  input wire logic [7:0][adcseq_pkg::RES_W-1:0] level,
  output var logic                   comp_in
);
  import adcseq_pkg::*;
  always_comb comp_in = (level[analog_mux_sel] >= dac_code);
endmodule : adcseq_partner

`default_nettype wire

// *** tb/adcseq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_tb_top;
  import adcseq_pkg::*;
  logic mclk, nrst, ctrl1_wr, ctrl2_wr, result_upper_rd, standby_req, comp_in;
  logic eoc, busy, irq, aid, lad, ld;
  logic [7:0] ctrl1_wdata, ctrl2_wdata, cc1, cc2, rup, rlo;
  logic [2:0] msel;
  logic [RES_W-1:0] dac, held;
  logic [7:0][RES_W-1:0] level;
  logic [RES_W-1:0] expq[$];
  int mismatches, checks_done, seed, i;

  adcseq_top dut (.mclk(mclk), .nrst(nrst), .ctrl1_wr(ctrl1_wr), .ctrl1_wdata(ctrl1_wdata), .ctrl2_wr(ctrl2_wr),
    .ctrl2_wdata(ctrl2_wdata), .result_upper_rd(result_upper_rd), .standby_req(standby_req), .comp_in(comp_in),
    .conv_control_one(cc1), .conv_control_two(cc2), .result_upper_reg(rup), .result_lower_status_reg(rlo),
    .end_of_conv_flag(eoc), .conv_busy_flag(busy), .conv_done_irq(irq), .analog_mux_sel(msel),
    .analog_input_disable(aid), .ladder_connect(lad), .dac_code(dac));
  adcseq_partner far (.analog_mux_sel(msel), .dac_code(dac), .level(level), .comp_in(comp_in));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic wr1(input logic [7:0] d);
    ctrl1_wr = 1'b1;
    ctrl1_wdata = d;
    tick(1);
    ctrl1_wr = 1'b0;
    tick(1);
  endtask : wr1

  task automatic wr2(input logic [7:0] d);
    ctrl2_wr = 1'b1;
    ctrl2_wdata = d;
    tick(1);
    ctrl2_wr = 1'b0;
    tick(1);
  endtask : wr2

  task automatic rd();
    result_upper_rd = 1'b1;
    tick(1);
    result_upper_rd = 1'b0;
    tick(1);
  endtask : rd

  task automatic wait_irq(input int n);
    int k;
    for (k = 0; k < n && irq !== 1'b1; k++) tick(1);
    if (irq !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_irq

  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Result monitor
  always @(posedge mclk) begin
    #2;
    if (irq === 1'b1) begin
      if (expq.size() == 0) chk(16'h0001, 16'h0000);
      else chk(16'({rup, rlo[7:6]}), 16'(expq.pop_front()));
      chk(16'(eoc), 16'h0001);
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    seed = 32'h1B8DA84A;
    {nrst, ctrl1_wr, ctrl2_wr, result_upper_rd, standby_req} = 5'h00;
    ctrl1_wdata = 8'h00;
    ctrl2_wdata = 8'h00;
    for (i = 0; i < 8; i++) level[i] = 10'($random(seed));
    tick(20);
    nrst = 1'b1;
    chk({cc1, cc2}, {CTRL1_RESET, CTRL2_RESET});
    chk({rup, rlo}, 16'h0000);
    chk(16'({aid, lad}), 16'h0002);
    // Every channel and time code, odd passes leave the result unread
    for (i = 0; i < 8; i++) begin
      ld = 1'($random(seed));
      wr1({1'b0, MODE_SINGLE, 1'b0, 4'(i)});
      wr2({2'h0, ld, 1'b1, 3'(i), 1'b0});
      chk(16'(cc2), 16'({2'h0, ld, 1'b1, 3'(i), 1'b0}));
      expq.push_back(level[i]);
      wr1({1'b1, MODE_SINGLE, 1'b0, 4'(i)});
      chk(16'({cc1[7], busy, eoc, lad}), 16'h0005);
      chk(16'(msel), 16'(i));
      if (i != 0 && !i[0]) chk(16'({rup, rlo[7:6]}), 16'(held));
      wait_irq(1300);
      chk(16'(busy), 16'h0000);
      chk(16'({lad, aid}), 16'({ld, 1'b0}));
      if (i[0]) held = {rup, rlo[7:6]};
      else rd();
      if (!i[0]) chk(16'(eoc), 16'h0000);
    end
    wr1({1'b1, MODE_SINGLE, 1'b0, 4'h9});
    tick(40);
    chk(16'(busy), 16'h0000);
    // Reserved mode never starts a conversion
    wr1({1'b1, 2'h2, 1'b0, 4'h1});
    tick(40);
    chk(16'({busy, cc1}), 16'h0041);
    // Repeat mode, then disable in mid-conversion
    wr1({1'b0, MODE_REPEAT, 1'b0, 4'h5});
    wr2(8'h10);
    repeat (3) expq.push_back(level[5]);
    wr1({1'b1, MODE_REPEAT, 1'b0, 4'h5});
    repeat (3) begin
      wait_irq(60);
      tick(1);
    end
    tick(10);
    held = {rup, rlo[7:6]};
    wr1({1'b0, MODE_OFF, 1'b0, 4'h5});
    chk(16'(busy), 16'h0000);
    tick(80);
    chk(16'({rup, rlo[7:6]}), 16'(held));
    // Standby in mid-conversion
    wr1({1'b0, MODE_SINGLE, 1'b0, 4'h2});
    wr2(8'h3C);
    wr1({1'b1, MODE_SINGLE, 1'b0, 4'h2});
    tick(100);
    standby_req = 1'b1;
    tick(2);
    chk({cc1, cc2}, {CTRL1_RESET, CTRL2_RESET});
    chk(16'({busy, eoc, lad}), 16'h0000);
    chk(16'({rup, rlo[7:6]}), 16'(RESULT_RESET));
    wr1({1'b1, MODE_SINGLE, 1'b0, 4'h2});
    chk(16'(cc1), 16'(CTRL1_RESET));
    standby_req = 1'b0;
    tick(50);
    chk(16'({busy, cc1}), 16'(CTRL1_RESET));
    wr1({1'b0, MODE_SINGLE, 1'b0, 4'h2});
    wr2(8'h10);
    expq.push_back(level[2]);
    wr1({1'b1, MODE_SINGLE, 1'b0, 4'h2});
    wait_irq(100);
    rd();
    tick(5);
    wrap_up();
  end
endmodule : adcseq_tb_top

`default_nettype wire
